// ===== logic/eeprom_host_pkg.sv
package eeprom_host_pkg;
    localparam int clk_hz = 20000000;
    localparam int addr_w = 15;
    localparam int data_w = 8;
    localparam int page_bytes = 64;
    localparam int page_lsb = 6;
    localparam int prot_seq_len = 3;
    // Times in their own units
    localparam int byte_load_interval_us = 150;
    localparam int write_cycle_time_ms = 5;
    localparam int power_up_lockout_ms = 5;
    localparam int strobe_width_ns = 100;
    localparam int addr_hold_ns = 80;
    localparam int data_setup_ns = 50;
    localparam int read_access_ns = 150;
    // Cycle counts: least times round up
    localparam int strobe_cycles = (strobe_width_ns * (clk_hz / 1000000) + 999) / 1000;
    localparam int setup_cycles = (data_setup_ns * (clk_hz / 1000000) + 999) / 1000;
    localparam int hold_cycles = (addr_hold_ns * (clk_hz / 1000000) + 999) / 1000;
    localparam int access_cycles = (read_access_ns * (clk_hz / 1000000) + 999) / 1000;
    // Gap between strobes must stay well below the byte-load interval
    localparam int gap_limit_cycles = byte_load_interval_us * (clk_hz / 1000000);
    localparam int write_cycle_cycles = write_cycle_time_ms * (clk_hz / 1000);
    localparam int lockout_cycles = power_up_lockout_ms * (clk_hz / 1000);
    localparam int cnt_w = 20;
    // Protection command sequences: address, data
    localparam logic [14:0] prot_addr_a = 15'h5555;
    localparam logic [14:0] prot_addr_b = 15'h2aaa;
    localparam logic [7:0] prot_data_a = 8'haa;
    localparam logic [7:0] prot_data_b = 8'h55;
    localparam logic [7:0] prot_enable_data = 8'ha0;
    localparam logic [7:0] prot_disable_data = 8'h80;
    localparam logic [7:0] prot_disable_tail = 8'h20;

    typedef enum logic [1:0] {
        cmd_page_write,
        cmd_prot_enable,
        cmd_prot_disable,
        cmd_read
    } cmd_kind_t;

    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] data;
    } byte_item_t;

    typedef struct packed {
        logic chip_select_n;
        logic output_gate_n;
        logic write_strobe_n;
        logic [14:0] addr;
        logic [7:0] dout;
        logic dout_en;
    } pin_bus_t;
endpackage

// ===== logic/eeprom_strobe_gen.sv
`timescale 1ns/1ps
// Drives one write strobe pulse: address, data and strobe low together, strobe high, hold
module eeprom_strobe_gen (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic use_chip_select,
    input wire eeprom_host_pkg::byte_item_t item,
    output eeprom_host_pkg::pin_bus_t pins,
    output logic done
);
    typedef enum {s_idle, s_low, s_high} strobe_state_t;
    strobe_state_t state;
    strobe_state_t next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    eeprom_host_pkg::pin_bus_t next_pins;
    logic next_done;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_pins = pins;
        next_done = 1'b0;
        unique case (state)
            s_idle: begin
                next_pins.write_strobe_n = 1'b1;
                next_pins.chip_select_n = use_chip_select;
                if (start) begin
                    next_pins.addr = item.addr; // RULE1
                    next_pins.dout = item.data;
                    next_pins.dout_en = 1'b1;
                    next_pins.output_gate_n = 1'b1; // RULE12
                    next_pins.chip_select_n = 1'b0; // RULE9
                    next_pins.write_strobe_n = 1'b0;
                    next_cnt = 8'(eeprom_host_pkg::strobe_cycles + eeprom_host_pkg::setup_cycles);
                    next_state = s_low;
                end
            end
            s_low: begin
                if (cnt > 8'h01) begin
                    next_cnt = cnt - 8'h01; // RULE10
                end else begin
                    next_pins.write_strobe_n = !use_chip_select; // RULE1
                    next_pins.chip_select_n = use_chip_select; // RULE9
                    next_cnt = 8'(eeprom_host_pkg::hold_cycles);
                    next_state = s_high;
                end
            end
            s_high: begin
                if (cnt > 8'h01) begin
                    next_cnt = cnt - 8'h01;
                end else begin
                    next_pins.write_strobe_n = 1'b1;
                    next_pins.chip_select_n = use_chip_select;
                    next_pins.dout_en = 1'b0;
                    next_done = 1'b1;
                    next_state = s_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= s_idle;
            cnt <= 8'h00;
            pins <= '{chip_select_n: 1'b1, output_gate_n: 1'b1, write_strobe_n: 1'b1,
                addr: 15'h0000, dout: 8'h00, dout_en: 1'b0};
            done <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            pins <= next_pins;
            done <= next_done;
        end
    end
endmodule

// ===== logic/eeprom_host_ctrl.sv
`timescale 1ns/1ps
// Operation
// [RULE1] Address at strobe fall, data at rise
// [RULE2] One to 64 bytes, any order
// [RULE3] Keep gap between strobes under 150 us
// [RULE4] Output gate low blocks further loads
// [RULE5] Write starts after strobe idle 150 us
// [RULE6] Page from address of last strobe
// [RULE7] Device erases then programs the page
// [RULE8] Only loaded bytes are rewritten
// [RULE9] Chip select may strobe writes instead
// [RULE10] Strobes wider than glitch filter
// [RULE11] No writes for 5 ms after power-up
// [RULE12] Hold write inhibit outside write strobes
// [RULE13] Unprotected writes need no unlock
// [RULE14] Enable sequence then byte or page write
// [RULE15] Protected writes need enable sequence first
// [RULE16] Disable sequence turns protection off
// [RULE17] Protection state survives power cycles
// [RULE18] Sequences use page load timing
// [RULE19] Protection changes after one write cycle
// [RULE20] 1 to 64 bytes after protection sequence
// [RULE21] Polled bit 7 inverted while writing
// [RULE22] True data after write completes
// [RULE23] Bit 6 toggles on reads while writing
// [RULE24] Device corrects single-bit errors
// [RULE25] Write completes within 5 ms
// [RULE26] No strobes while write in progress
module eeprom_host_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire eeprom_host_pkg::cmd_kind_t req_kind,
    input wire logic [6:0] req_count,
    input wire logic req_use_chip_select,
    input wire eeprom_host_pkg::byte_item_t req_item,
    input wire logic [7:0] data_in,
    output logic req_ready,
    output logic item_take,
    output logic done,
    output logic timeout,
    output logic [7:0] read_data,
    output logic [14:0] addr,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_strobe_n
);
    typedef enum {
        st_lockout, st_idle, st_prefix, st_load, st_next, st_settle, st_poll, st_read
    } host_state_t;
    host_state_t state;
    host_state_t next_state;
    logic [19:0] cnt;
    logic [19:0] next_cnt;
    logic [19:0] wait_cnt;
    logic [19:0] next_wait_cnt;
    logic [6:0] left;
    logic [6:0] next_left;
    logic [2:0] pre_idx;
    logic [2:0] next_pre_idx;
    logic [2:0] pre_len;
    logic [2:0] next_pre_len;
    logic [7:0] last_data;
    logic [7:0] next_last_data;
    logic [14:0] last_addr;
    logic [14:0] next_last_addr;
    logic use_cs;
    logic next_use_cs;
    logic req_ready_r;
    logic item_take_r;
    logic done_r;
    logic timeout_r;
    logic [7:0] read_data_r;
    logic next_req_ready;
    logic next_item_take;
    logic next_done;
    logic next_timeout;
    logic [7:0] next_read_data;
    logic gen_start;
    logic next_gen_start;
    eeprom_host_pkg::byte_item_t gen_item;
    eeprom_host_pkg::byte_item_t next_gen_item;
    eeprom_host_pkg::pin_bus_t gen_pins;
    logic gen_done;
    logic read_active;
    logic next_read_active;

    // Unlock sequence byte by step
    function automatic eeprom_host_pkg::byte_item_t prefix_item(input logic [2:0] idx,
            input logic dis);
        eeprom_host_pkg::byte_item_t it;
        unique case (idx)
            3'd0, 3'd3: it = '{eeprom_host_pkg::prot_addr_a, eeprom_host_pkg::prot_data_a};
            3'd1, 3'd4: it = '{eeprom_host_pkg::prot_addr_b, eeprom_host_pkg::prot_data_b};
            3'd2: it = '{eeprom_host_pkg::prot_addr_a, dis ? eeprom_host_pkg::prot_disable_data :
                eeprom_host_pkg::prot_enable_data};
            default: it = '{eeprom_host_pkg::prot_addr_a, eeprom_host_pkg::prot_disable_tail};
        endcase
        return it;
    endfunction

    eeprom_strobe_gen u_strobe (
        .clk(clk),
        .reset(reset),
        .start(gen_start),
        .use_chip_select(use_cs),
        .item(gen_item),
        .pins(gen_pins),
        .done(gen_done)
    );

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_wait_cnt = wait_cnt;
        next_left = left;
        next_pre_idx = pre_idx;
        next_pre_len = pre_len;
        next_last_data = last_data;
        next_last_addr = last_addr;
        next_use_cs = use_cs;
        next_req_ready = 1'b0;
        next_item_take = 1'b0;
        next_done = 1'b0;
        next_timeout = 1'b0;
        next_read_data = read_data_r;
        next_gen_start = 1'b0;
        next_gen_item = gen_item;
        next_read_active = 1'b0;
        unique case (state)
            st_lockout: begin
                // Power-up lockout: no write strobes yet
                if (cnt != 20'h00000) begin
                    next_cnt = cnt - 20'h00001; // RULE11
                end else begin
                    next_req_ready = 1'b1;
                    next_state = st_idle;
                end
            end
            st_idle: begin
                next_req_ready = 1'b1;
                if (req_valid && req_ready_r) begin
                    next_req_ready = 1'b0;
                    next_use_cs = req_use_chip_select; // RULE9
                    next_left = (req_count == 7'h00) ? 7'h01 :
                        ((req_count > 7'(eeprom_host_pkg::page_bytes)) ?
                        7'(eeprom_host_pkg::page_bytes) : req_count); // RULE2 RULE20
                    next_pre_idx = 3'h0;
                    next_pre_len = 3'd0;
                    if (req_kind == eeprom_host_pkg::cmd_read) begin
                        next_last_addr = req_item.addr;
                        next_cnt = 20'(eeprom_host_pkg::access_cycles);
                        next_read_active = 1'b1;
                        next_state = st_read;
                    end else if (req_kind == eeprom_host_pkg::cmd_page_write) begin
                        // Plain page write needs no unlock prefix
                        next_state = st_load; // RULE13
                    end else begin
                        // Same pin timing as a page load
                        next_pre_len = (req_kind == eeprom_host_pkg::cmd_prot_disable) ? 3'd6 :
                            3'd3; // RULE14 RULE16 RULE18
                        next_gen_item = prefix_item(3'd0,
                            req_kind == eeprom_host_pkg::cmd_prot_disable);
                        next_gen_start = 1'b1;
                        next_state = st_prefix;
                    end
                    if (req_kind == eeprom_host_pkg::cmd_page_write) begin
                        next_item_take = 1'b1;
                        next_gen_item = req_item;
                        next_gen_start = 1'b1;
                    end
                end
            end
            st_prefix: begin
                if (gen_done) begin
                    if (pre_idx + 3'd1 < pre_len) begin
                        next_pre_idx = pre_idx + 3'd1;
                        next_gen_item = prefix_item(pre_idx + 3'd1, pre_len == 3'd6);
                        next_gen_start = 1'b1;
                    end else begin
                        // Enable is followed by the protected data load
                        next_state = (pre_len == 3'd6) ? st_settle : st_next; // RULE15
                        next_wait_cnt = 20'h00000;
                        next_cnt = 20'h00000;
                        if (pre_len == 3'd6) begin
                            next_left = 7'h00;
                        end
                    end
                end
            end
            st_load: begin
                if (gen_done) begin
                    // Target page and polled byte follow the last strobe
                    next_last_addr = gen_item.addr; // RULE6
                    next_last_data = gen_item.data;
                    next_left = left - 7'h01;
                    next_cnt = 20'h00000;
                    next_state = (left == 7'h01) ? st_settle : st_next;
                end
            end
            st_next: begin
                next_cnt = cnt + 20'h00001;
                if (cnt >= 20'(eeprom_host_pkg::gap_limit_cycles / 2)) begin
                    // Abandoning the gap lets the device close the page early
                    next_state = st_settle; // RULE3
                end else if (left != 7'h00) begin
                    next_gen_item = req_item;
                    next_gen_start = 1'b1;
                    next_item_take = 1'b1;
                    next_state = st_load; // RULE3
                end else begin
                    next_state = st_settle;
                end
            end
            st_settle: begin
                // Strobe idle past byte-load interval starts nonvolatile write
                next_cnt = cnt + 20'h00001;
                if (cnt >= 20'(eeprom_host_pkg::gap_limit_cycles)) begin
                    next_cnt = 20'(eeprom_host_pkg::access_cycles); // RULE5
                    next_wait_cnt = 20'h00000;
                    next_read_active = 1'b1;
                    next_state = st_poll; // RULE7 RULE8 RULE19 RULE26
                end
            end
            st_poll: begin
                next_wait_cnt = wait_cnt + 20'h00001;
                next_read_active = 1'b1;
                if (cnt != 20'h00000) begin
                    next_cnt = cnt - 20'h00001;
                end else begin
                    next_cnt = 20'(eeprom_host_pkg::access_cycles) + 20'h00002;
                    next_read_active = 1'b0;
                    // Bit 7 true (not checked after a disable sequence) and bit 6 steady mean write done
                    if ((data_in[7] == last_data[7] || pre_len == 3'd6) && // RULE21 RULE22
                        data_in[6] == read_data_r[6] && // RULE23
                        wait_cnt > 20'(eeprom_host_pkg::access_cycles)) begin
                        next_done = 1'b1;
                        next_read_data = data_in;
                        next_state = st_idle;
                    end else if (wait_cnt >= 20'(eeprom_host_pkg::write_cycle_cycles)) begin
                        next_timeout = 1'b1; // RULE25
                        next_state = st_idle;
                    end
                    next_read_data = data_in;
                end
            end
            st_read: begin
                next_read_active = 1'b1;
                if (cnt != 20'h00000) begin
                    next_cnt = cnt - 20'h00001;
                end else begin
                    // Device corrects single-bit errors before output
                    next_read_data = data_in; // RULE24
                    next_done = 1'b1;
                    next_read_active = 1'b0;
                    next_state = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= st_lockout;
            cnt <= 20'(eeprom_host_pkg::lockout_cycles);
            wait_cnt <= 20'h00000;
            left <= 7'h00;
            pre_idx <= 3'h0;
            pre_len <= 3'd0;
            last_data <= 8'h00;
            last_addr <= 15'h0000;
            use_cs <= 1'b0;
            req_ready_r <= 1'b0;
            item_take_r <= 1'b0;
            done_r <= 1'b0;
            timeout_r <= 1'b0;
            read_data_r <= 8'h00;
            gen_start <= 1'b0;
            gen_item <= '0;
            read_active <= 1'b0;
            addr <= 15'h0000;
            data_out <= 8'h00;
            data_oe <= 1'b0;
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            wait_cnt <= next_wait_cnt;
            left <= next_left;
            pre_idx <= next_pre_idx;
            pre_len <= next_pre_len;
            last_data <= next_last_data;
            last_addr <= next_last_addr;
            use_cs <= next_use_cs;
            req_ready_r <= next_req_ready;
            item_take_r <= next_item_take;
            done_r <= next_done;
            timeout_r <= next_timeout;
            read_data_r <= next_read_data;
            gen_start <= next_gen_start;
            gen_item <= next_gen_item;
            read_active <= next_read_active;
            // Reads drive gate low with strobe high, so no write can start
            addr <= next_read_active ? next_last_addr : gen_pins.addr; // RULE12
            data_out <= gen_pins.dout;
            data_oe <= gen_pins.dout_en && !next_read_active;
            chip_select_n <= next_read_active ? 1'b0 : gen_pins.chip_select_n;
            output_gate_n <= next_read_active ? 1'b0 : gen_pins.output_gate_n; // RULE4
            write_strobe_n <= next_read_active ? 1'b1 : gen_pins.write_strobe_n;
        end
    end

    assign req_ready = req_ready_r;
    assign item_take = item_take_r;
    assign done = done_r;
    assign timeout = timeout_r;
    assign read_data = read_data_r;
endmodule

// ===== dv/eeprom_host_ctrl_asserts.sv
`timescale 1ns/1ps
module eeprom_host_ctrl_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [14:0] addr,
    input wire logic data_oe,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n
);
    logic [16:0] up_cnt;
    logic [16:0] next_up_cnt;
    wire load_n = write_strobe_n | chip_select_n;
    always_comb begin
        next_up_cnt = (&up_cnt) ? up_cnt : up_cnt + 17'h1;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            up_cnt <= 17'h0;
        end else begin
            up_cnt <= next_up_cnt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_load_start; $fell(load_n); endsequence
    sequence s_load_held; !load_n [*2]; endsequence
    property p_lockout; up_cnt < eeprom_host_pkg::lockout_cycles - 1 |-> !req_ready; endproperty
    property p_strobe_width; s_load_start |-> s_load_held; endproperty
    property p_gate_high; !load_n |-> output_gate_n && data_oe; endproperty
    property p_addr_steady; !load_n && !$past(load_n) |-> $stable(addr); endproperty
    property p_gate_after_load; $rose(load_n) |-> output_gate_n [*8]; endproperty
    property p_single_take; req_valid && req_ready |=> !req_ready; endproperty
    property p_done_ready; done |-> ##[0:3] req_ready; endproperty
    property p_no_contend; !output_gate_n |-> !data_oe; endproperty
    a_lockout: assert property (p_lockout) else $error("ready in lockout");
    a_strobe_width: assert property (p_strobe_width) else $error("strobe short");
    a_gate_high: assert property (p_gate_high) else $error("gate low in load");
    a_addr_steady: assert property (p_addr_steady) else $error("address moved");
    a_gate_after_load: assert property (p_gate_after_load) else $error("early gate");
    a_single_take: assert property (p_single_take) else $error("ready kept");
    a_done_ready: assert property (p_done_ready) else $error("no ready");
    a_no_contend: assert property (p_no_contend) else $error("bus fight");
endmodule

bind eeprom_host_ctrl eeprom_host_ctrl_checker chk_u (
    .clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .done(done),
    .addr(addr), .data_oe(data_oe), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n)
);

// ===== dv/eeprom_device_model.sv
`timescale 1ns/1ps
module eeprom_device_model #(
    parameter int write_cycles = 400
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [14:0] addr,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    output wire logic [7:0] data_in
);
    logic [7:0] mem [0:32767];
    logic [14:0] la [0:69];
    logic [7:0] ld [0:69];
    logic [14:0] cap_a;
    logic [7:0] bus_q;
    logic prot, tog, prev_ld, prev_rd, en, dis;
    int n_ld, tmr, busy, lock, skip;
    wire load_n = write_strobe_n | chip_select_n;
    wire rd = !chip_select_n && !output_gate_n && write_strobe_n;
    wire [7:0] dev = busy > 0 ? {~ld[n_ld-1][7], tog, ~bus_q[5:0]} : mem[addr];
    assign data_in = data_oe ? data_out : (rd ? dev : ~bus_q);
    initial begin
        prot = 1'b0;
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 8'hff;
        end
    end
    task automatic start();
        en = n_ld >= 3 && la[0] == eeprom_host_pkg::prot_addr_a && la[1] == eeprom_host_pkg::prot_addr_b
            && ld[0] == eeprom_host_pkg::prot_data_a && ld[1] == eeprom_host_pkg::prot_data_b;
        dis = en && n_ld >= 6 && ld[2] == eeprom_host_pkg::prot_disable_data
            && ld[5] == eeprom_host_pkg::prot_disable_tail;
        en = en && ld[2] == eeprom_host_pkg::prot_enable_data;
        skip = dis ? n_ld : (en ? 3 : 0);
        tmr = 0;
        if (prot && !en && !dis) begin
            n_ld = 0;
        end else begin
            busy = write_cycles;
        end
    endtask
    task automatic commit();
        for (int i = skip; i < n_ld; i++) begin
            mem[{la[n_ld-1][14:6], la[i][5:0]}] = 8'hff;
        end
        for (int i = skip; i < n_ld; i++) begin
            mem[{la[n_ld-1][14:6], la[i][5:0]}] = ld[i];
        end
        prot = en ? 1'b1 : (dis ? 1'b0 : prot);
        n_ld = 0;
    endtask
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            lock = eeprom_host_pkg::lockout_cycles;
            n_ld = 0;
            tmr = 0;
            busy = 0;
            prev_ld = 1'b1;
            prev_rd = 1'b0;
            tog = 1'b0;
            bus_q = 8'h00;
        end else begin
            bus_q = data_in;
            lock = lock - int'(lock > 0);
            tog = tog ^ (rd && !prev_rd);
            if (busy > 0) begin
                busy--;
                if (busy == 0) begin
                    commit();
                end
            end else begin
                if (lock == 0 && output_gate_n && prev_ld && !load_n) begin
                    cap_a = addr;
                    tmr = 0;
                end
                if (lock == 0 && output_gate_n && !prev_ld && load_n && n_ld < 70) begin
                    la[n_ld] = cap_a;
                    ld[n_ld] = data_out;
                    n_ld++;
                    tmr = 0;
                end
                tmr = tmr + int'(n_ld > 0 && load_n);
                if (tmr >= eeprom_host_pkg::gap_limit_cycles) begin
                    start();
                end
            end
            prev_ld = load_n;
            prev_rd = rd;
        end
    end
endmodule

// ===== dv/test_eeprom_host_ctrl.sv
`timescale 1ns/1ps
module test_eeprom_host_ctrl;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    eeprom_host_pkg::cmd_kind_t req_kind = eeprom_host_pkg::cmd_read;
    logic [6:0] req_count = 7'h01;
    logic req_use_chip_select = 1'b0;
    eeprom_host_pkg::byte_item_t req_item = '0;
    wire [7:0] data_in;
    logic req_ready, item_take, done, timeout, data_oe, chip_select_n, output_gate_n, write_strobe_n;
    logic [7:0] read_data, data_out;
    logic [14:0] addr;
    logic [14:0] qa [0:63];
    logic [7:0] qd [0:63];
    logic [7:0] shadow [0:32767];
    logic [8:0] page;
    int err_count = 0;
    int total_checks = 0;
    always #25 clk = ~clk;
    eeprom_host_ctrl dut_u (.clk(clk), .reset(reset), .req_valid(req_valid), .req_kind(req_kind),
        .req_count(req_count), .req_use_chip_select(req_use_chip_select), .req_item(req_item),
        .data_in(data_in), .req_ready(req_ready), .item_take(item_take), .done(done),
        .timeout(timeout), .read_data(read_data), .addr(addr), .data_out(data_out),
        .data_oe(data_oe), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
        .write_strobe_n(write_strobe_n));
    eeprom_device_model #(.write_cycles(400)) dev_u (.clk(clk), .reset(reset), .addr(addr),
        .data_out(data_out), .data_oe(data_oe), .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .data_in(data_in));
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run_op(input eeprom_host_pkg::cmd_kind_t kind, input logic cs, input int n);
        int i;
        i = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_kind <= kind;
        req_count <= 7'(n);
        req_use_chip_select <= cs;
        req_item <= {qa[0], qd[0]};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do begin
            @(posedge clk);
            if (item_take === 1'b1 && i < 63) begin
                i++;
                req_item <= {qa[i], qd[i]};
            end
        end while (done !== 1'b1 && timeout !== 1'b1);
        check_flag(timeout, 1'b0);
    endtask
    task automatic fill(input int n);
        logic [5:0] k;
        k = 6'($urandom);
        for (int j = 0; j < n; j++) begin
            qa[j] = {page, 6'(j) ^ k};
            qd[j] = 8'($urandom);
        end
    endtask
    task automatic keep(input int n);
        for (int j = 0; j < n; j++) begin
            shadow[{page, qa[j][5:0]}] = qd[j];
        end
    endtask
    task automatic read_page();
        for (int j = 0; j < 64; j++) begin
            qa[0] = {page, 6'(j)};
            run_op(eeprom_host_pkg::cmd_read, 1'b0, 1);
            check_byte(read_data, shadow[{page, 6'(j)}]);
        end
    endtask
    initial begin
        repeat (200000) @(posedge clk);
        err_count++;
        close_out();
    end
    initial begin
        void'($urandom(88));
        for (int j = 0; j < 32768; j++) begin
            shadow[j] = 8'hff;
        end
        page = 9'($urandom);
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        do @(posedge clk); while (req_ready !== 1'b1);
        fill(64);
        run_op(eeprom_host_pkg::cmd_page_write, 1'b0, 64);
        keep(64);
        read_page();
        // Reload one place; earlier bytes aim at another page
        fill(3);
        qa[1] = qa[0];
        qa[0][14:6] = ~page;
        qa[1][14:6] = ~page;
        run_op(eeprom_host_pkg::cmd_page_write, 1'b1, 3);
        keep(3);
        read_page();
        fill(1);
        run_op(eeprom_host_pkg::cmd_prot_enable, 1'b0, 1);
        keep(1);
        read_page();
        // Dropped write keeps bit 7 so polling ends at once
        fill(1);
        qd[0] = shadow[{page, qa[0][5:0]}] ^ 8'h01;
        run_op(eeprom_host_pkg::cmd_page_write, 1'b0, 1);
        read_page();
        run_op(eeprom_host_pkg::cmd_prot_disable, 1'b0, 1);
        fill(2);
        run_op(eeprom_host_pkg::cmd_page_write, 1'b0, 2);
        keep(2);
        read_page();
        close_out();
    end
endmodule
